// ==== pkg/cafm_pkg.sv ====
// constants and types for the acceptance filter map block
package cafm_pkg;
  localparam int NUM_FILT = 16;
  localparam int NUM_MASK = 3;
  localparam int NUM_BUFPNT = 4;
  // register byte addresses
  localparam logic [11:0] ADDR_BUFPNT_BASE = 12'h000;
  localparam logic [11:0] ADDR_FEN = 12'h010;
  localparam logic [11:0] ADDR_MSKSEL1 = 12'h014;
  localparam logic [11:0] ADDR_HIT_STATUS = 12'h018;
  localparam logic [11:0] ADDR_HIT_COUNT = 12'h01c;
  localparam logic [6:0] ADDR_MASK_PAGE = 7'h01;
  localparam logic [3:0] ADDR_FILT_PAGE = 4'h1;
  // reset values
  localparam logic [15:0] BUFPNT_RESET = 16'h0000;
  localparam logic [15:0] FEN_RESET = 16'hffff;
  localparam logic [15:0] MSKSEL_RESET = 16'h0000;
  localparam logic [15:0] ID_RESET = 16'h0000;
  // bits 4 and 2 of the standard-id words are unimplemented
  localparam logic [15:0] SID_WR_MASK = 16'hffeb;
  // field positions
  localparam int SID_HI = 15;
  localparam int SID_LO = 5;
  localparam int IDE_BIT = 3;
  localparam int PTR_W = 4;
  localparam int MSEL_W = 2;
  localparam int HIT_FLAG_BIT = 15;
  // mask source codes
  localparam logic [1:0] MSEL_MASK0 = 2'h0;
  localparam logic [1:0] MSEL_MASK1 = 2'h1;
  localparam logic [1:0] MSEL_MASK2 = 2'h2;
  // pointer code that routes a hit into the receive fifo
  localparam logic [3:0] PTR_FIFO = 4'hf;
  typedef enum logic [1:0] {CAFM_IDLE, CAFM_ACK} cafm_apb_state_t;
endpackage

// ==== design/cafm_filter_cmp.sv ====
// one acceptance filter: mask choice and identifier comparison
`timescale 1ns/10ps
`default_nettype none
module cafm_filter_cmp
  import cafm_pkg::*;
(
  // filter pattern
  input wire logic [15:0] filt_sid,
  input wire logic [15:0] filt_eid,
  input wire logic filter_accept_enable,
  input wire logic [1:0] mask_source_select,
  // the three acceptance masks
  input wire logic [2:0][15:0] mask_sid,
  input wire logic [2:0][15:0] mask_eid,
  // received identifier
  input wire logic rx_ide,
  input wire logic [10:0] rx_sid,
  input wire logic [17:0] rx_eid,
  // result
  output logic match
);
  logic [15:0] msid;
  logic [15:0] meid;
  logic sel_ok;
  logic sid_ok;
  logic eid_ok;
  logic type_ok;

  always_comb begin
    msid = mask_sid[0];
    meid = mask_eid[0];
    sel_ok = 1'b1;
    case (mask_source_select)
      MSEL_MASK0: begin
        msid = mask_sid[0];
        meid = mask_eid[0];
      end
      MSEL_MASK1: begin
        msid = mask_sid[1];
        meid = mask_eid[1];
      end
      MSEL_MASK2: begin
        msid = mask_sid[2];
        meid = mask_eid[2];
      end
      default: sel_ok = 1'b0;
    endcase
    sid_ok = ((rx_sid ^ filt_sid[SID_HI:SID_LO]) & msid[SID_HI:SID_LO]) == 11'h000;
    eid_ok = (((rx_eid[17:16] ^ filt_sid[1:0]) & msid[1:0]) == 2'h0)
      && (((rx_eid[15:0] ^ filt_eid) & meid) == 16'h0000);
    type_ok = !msid[IDE_BIT] || (filt_sid[IDE_BIT] == rx_ide);
    match = filter_accept_enable && sel_ok && sid_ok && type_ok && (eid_ok || !rx_ide);
  end
endmodule
`default_nettype wire

// ==== design/cafm_prio.sv ====
// lowest-index selector over the filter match vector
`timescale 1ns/10ps
`default_nettype none
module cafm_prio
  import cafm_pkg::*;
(
  // match vector
  input wire logic [15:0] req,
  // winner
  output logic any,
  output logic [3:0] index
);
  always_comb begin
    any = |req;
    index = 4'h0;
    for (int i = NUM_FILT - 1; i >= 0; i--) begin
      if (req[i]) begin
        index = 4'(i);
      end
    end
  end
endmodule
`default_nettype wire

// ==== design/cafm_top.sv ====
// acceptance filter map: filter registers, masks, pointers and hit routing
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module cafm_top
  import cafm_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // received identifier
  input wire logic rx_valid,
  input wire logic rx_ide,
  input wire logic [10:0] rx_sid,
  input wire logic [17:0] rx_eid,
  // hit result
  output logic filter_hit,
  output logic [3:0] hit_filter_index,
  output logic [3:0] hit_buffer_pointer,
  output logic hit_to_fifo
);
  // register state
  logic [15:0] bufpnt [NUM_BUFPNT];
  logic [15:0] next_bufpnt [NUM_BUFPNT];
  logic [15:0] filter_accept_enable;
  logic [15:0] next_filter_accept_enable;
  logic [15:0] mask_select1;
  logic [15:0] next_mask_select1;
  logic [15:0] filt_sid [NUM_FILT];
  logic [15:0] next_filt_sid [NUM_FILT];
  logic [15:0] filt_eid [NUM_FILT];
  logic [15:0] next_filt_eid [NUM_FILT];
  logic [2:0][15:0] mask_sid;
  logic [2:0][15:0] next_mask_sid;
  logic [2:0][15:0] mask_eid;
  logic [2:0][15:0] next_mask_eid;
  logic [15:0] hit_status;
  logic [15:0] next_hit_status;
  logic [15:0] hit_count;
  logic [15:0] next_hit_count;
  // bus state
  cafm_apb_state_t state;
  cafm_apb_state_t next_state;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  // hit outputs
  logic next_filter_hit;
  logic [3:0] next_hit_filter_index;
  logic [3:0] next_hit_buffer_pointer;
  logic next_hit_to_fifo;
  // decode
  logic is_filt;
  logic is_mask;
  logic is_ctl;
  logic mapped;
  logic [3:0] filt_idx;
  logic [1:0] mask_idx;
  logic [15:0] rd_word;
  logic [15:0] wr_lanes;
  logic wr_fire;
  // filtering
  logic [15:0] match_vec;
  logic [1:0] msel [NUM_FILT];
  logic [3:0] ptr [NUM_FILT];
  logic match_any;
  logic [3:0] match_idx;

  genvar g;
  generate
    for (g = 0; g < NUM_FILT; g++) begin : gen_filt
      if (g < 8) begin : gen_sel1
        assign msel[g] = mask_select1[g*MSEL_W +: MSEL_W];
      end else begin : gen_sel0
        assign msel[g] = MSEL_MASK0;
      end
      assign ptr[g] = bufpnt[g/4][(g%4)*PTR_W +: PTR_W];
      cafm_filter_cmp u_cmp (
        .filt_sid(filt_sid[g]),
        .filt_eid(filt_eid[g]),
        .filter_accept_enable(filter_accept_enable[g]),
        .mask_source_select(msel[g]),
        .mask_sid(mask_sid),
        .mask_eid(mask_eid),
        .rx_ide(rx_ide),
        .rx_sid(rx_sid),
        .rx_eid(rx_eid),
        .match(match_vec[g])
      );
    end
  endgenerate

  cafm_prio u_prio (
    .req(match_vec),
    .any(match_any),
    .index(match_idx)
  );

  // address decode and read mux
  always_comb begin
    filt_idx = paddr[6:3];
    mask_idx = paddr[4:3];
    is_filt = (paddr[11:8] == ADDR_FILT_PAGE) && (paddr[7] == 1'b0);
    is_mask = (paddr[11:5] == ADDR_MASK_PAGE) && (mask_idx != 2'h3);
    is_ctl = (paddr[11:5] == 7'h00);
    rd_word = 16'h0000;
    mapped = 1'b0;
    if (paddr[1:0] == 2'h0) begin
      if (is_filt) begin
        mapped = 1'b1;
        rd_word = paddr[2] ? filt_eid[filt_idx] : (filt_sid[filt_idx] & SID_WR_MASK);
      end else if (is_mask) begin
        mapped = 1'b1;
        rd_word = paddr[2] ? mask_eid[mask_idx] : (mask_sid[mask_idx] & SID_WR_MASK);
      end else if (is_ctl) begin
        mapped = 1'b1;
        case (paddr)
          ADDR_FEN: rd_word = filter_accept_enable;
          ADDR_MSKSEL1: rd_word = mask_select1;
          ADDR_HIT_STATUS: rd_word = hit_status;
          ADDR_HIT_COUNT: rd_word = hit_count;
          default: begin
            if (paddr[4] == 1'b0) begin
              rd_word = bufpnt[paddr[3:2]];
            end else begin
              mapped = 1'b0;
            end
          end
        endcase
      end
    end
  end

  // apb handshake: access phase is answered one cycle later
  always_comb begin
    next_state = state;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    case (state)
      CAFM_IDLE: begin
        if (psel && penable) begin
          next_state = CAFM_ACK;
          next_pready = 1'b1;
          next_pslverr = !mapped;
          next_prdata = (pwrite || !mapped) ? 32'h0000_0000 : {16'h0000, rd_word};
        end
      end
      CAFM_ACK: next_state = CAFM_IDLE;
      default: next_state = CAFM_IDLE;
    endcase
  end

  assign wr_fire = (state == CAFM_ACK) && psel && penable && pwrite && !pslverr;
  assign wr_lanes = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // register writes
  always_comb begin
    next_bufpnt = bufpnt;
    next_filter_accept_enable = filter_accept_enable;
    next_mask_select1 = mask_select1;
    next_filt_sid = filt_sid;
    next_filt_eid = filt_eid;
    next_mask_sid = mask_sid;
    next_mask_eid = mask_eid;
    if (wr_fire) begin
      if (is_filt) begin
        if (paddr[2]) begin
          next_filt_eid[filt_idx] = (filt_eid[filt_idx] & ~wr_lanes) | (pwdata[15:0] & wr_lanes);
        end else begin
          next_filt_sid[filt_idx] = ((filt_sid[filt_idx] & ~wr_lanes)
            | (pwdata[15:0] & wr_lanes)) & SID_WR_MASK;
        end
      end else if (is_mask) begin
        if (paddr[2]) begin
          next_mask_eid[mask_idx] = (mask_eid[mask_idx] & ~wr_lanes) | (pwdata[15:0] & wr_lanes);
        end else begin
          next_mask_sid[mask_idx] = ((mask_sid[mask_idx] & ~wr_lanes)
            | (pwdata[15:0] & wr_lanes)) & SID_WR_MASK;
        end
      end else if (paddr == ADDR_FEN) begin
        next_filter_accept_enable = (filter_accept_enable & ~wr_lanes) | (pwdata[15:0] & wr_lanes);
      end else if (paddr == ADDR_MSKSEL1) begin
        next_mask_select1 = (mask_select1 & ~wr_lanes) | (pwdata[15:0] & wr_lanes);
      end else if (paddr[11:4] == ADDR_BUFPNT_BASE[11:4]) begin
        next_bufpnt[paddr[3:2]] = (bufpnt[paddr[3:2]] & ~wr_lanes) | (pwdata[15:0] & wr_lanes);
      end
    end
  end

  // hit routing and status
  always_comb begin
    next_filter_hit = 1'b0;
    next_hit_filter_index = hit_filter_index;
    next_hit_buffer_pointer = hit_buffer_pointer;
    next_hit_to_fifo = 1'b0;
    next_hit_status = hit_status;
    next_hit_count = hit_count;
    // sticky flag cleared by writing one
    if (wr_fire && (paddr == ADDR_HIT_STATUS) && pstrb[1] && pwdata[HIT_FLAG_BIT]) begin
      next_hit_status[HIT_FLAG_BIT] = 1'b0;
    end
    if (rx_valid && match_any) begin
      next_filter_hit = 1'b1;
      next_hit_filter_index = match_idx;
      next_hit_buffer_pointer = ptr[match_idx];
      next_hit_to_fifo = (ptr[match_idx] == PTR_FIFO);
      next_hit_status = {1'b1, 7'h00, match_idx, ptr[match_idx]};
      next_hit_count = hit_count + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < NUM_BUFPNT; i++) begin
        bufpnt[i] <= BUFPNT_RESET;
      end
      filter_accept_enable <= FEN_RESET;
      mask_select1 <= MSKSEL_RESET;
      for (int i = 0; i < NUM_FILT; i++) begin
        filt_sid[i] <= ID_RESET;
        filt_eid[i] <= ID_RESET;
      end
      for (int i = 0; i < NUM_MASK; i++) begin
        mask_sid[i] <= ID_RESET;
        mask_eid[i] <= ID_RESET;
      end
      hit_status <= 16'h0000;
      hit_count <= 16'h0000;
      state <= CAFM_IDLE;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      filter_hit <= 1'b0;
      hit_filter_index <= 4'h0;
      hit_buffer_pointer <= 4'h0;
      hit_to_fifo <= 1'b0;
    end else if (ce) begin
      bufpnt <= next_bufpnt;
      filter_accept_enable <= next_filter_accept_enable;
      mask_select1 <= next_mask_select1;
      filt_sid <= next_filt_sid;
      filt_eid <= next_filt_eid;
      mask_sid <= next_mask_sid;
      mask_eid <= next_mask_eid;
      hit_status <= next_hit_status;
      hit_count <= next_hit_count;
      state <= next_state;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      filter_hit <= next_filter_hit;
      hit_filter_index <= next_hit_filter_index;
      hit_buffer_pointer <= next_hit_buffer_pointer;
      hit_to_fifo <= next_hit_to_fifo;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/cafm_checker.sv ====
// assertion checker for the acceptance filter map ports
`timescale 1ns/10ps
`default_nettype none
module cafm_checker
  import cafm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // receive side
  input wire logic rx_valid,
  input wire logic filter_hit,
  input wire logic [3:0] hit_buffer_pointer,
  input wire logic hit_to_fifo
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_apb_one_wait: assert property (psel && penable && !pready && ce |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready && ce |=> !pready)
    else $error("pready too long");
  a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read not zero");
  a_sid_gap_zero: assert property (pready && !pwrite && !pslverr && paddr[11:8] == 4'h1
    && !paddr[2] |-> prdata[4] == 1'b0 && prdata[2] == 1'b0 && prdata[31:16] == 16'h0)
    else $error("unimplemented bits set");
  a_hit_needs_rx: assert property (filter_hit && $past(ce) |-> $past(rx_valid))
    else $error("hit without frame");
  a_fifo_code: assert property (hit_to_fifo |-> filter_hit && hit_buffer_pointer == 4'hf)
    else $error("fifo flag wrong");
  a_fifo_given: assert property (filter_hit && hit_buffer_pointer == 4'hf |-> hit_to_fifo)
    else $error("fifo flag missing");
  a_reset_quiet: assert property ($past(reset) |-> !filter_hit && !pready && !pslverr)
    else $error("outputs busy after reset");
  c_write: cover property (pready && pwrite);
  c_error: cover property (pready && pslverr);
  c_hit: cover property (filter_hit && !hit_to_fifo);
  c_fifo: cover property (hit_to_fifo);
endmodule
bind cafm_top cafm_checker i_chk (.clk_sys(clk_sys), .reset(reset), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rx_valid(rx_valid), .filter_hit(filter_hit),
  .hit_buffer_pointer(hit_buffer_pointer), .hit_to_fifo(hit_to_fifo));
`default_nettype wire

// ==== testbench/cafm_can_node.sv ====
// behavioural can node presenting received identifiers
`timescale 1ns/10ps
`default_nettype none
module cafm_can_node (
  // clock
  input wire logic clk_sys,
  // received identifier
  output logic rx_valid,
  output logic rx_ide,
  output logic [10:0] rx_sid,
  output logic [17:0] rx_eid
);
  initial begin
    rx_valid = 1'b0;
    rx_ide = 1'b0;
    rx_sid = 11'h7ff;
    rx_eid = 18'h3ffff;
  end
  // one frame; ids go stale (inverted) once the frame is gone
  task automatic send(input logic ide, input logic [10:0] standard_identifier_bits, input logic [17:0] extended_identifier_bits);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_ide <= ide;
    rx_sid <= standard_identifier_bits;
    rx_eid <= extended_identifier_bits;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_ide <= ~ide;
    rx_sid <= ~standard_identifier_bits;
    rx_eid <= ~extended_identifier_bits;
  endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the acceptance filter map
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import cafm_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic ce = 1'b1;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr;
  logic rx_valid, rx_ide, filter_hit, hit_to_fifo;
  logic [10:0] rx_sid;
  logic [17:0] rx_eid;
  logic [3:0] hit_filter_index, hit_buffer_pointer;
  int n_errors = 0;
  int samples_checked = 0;
  always #10 clk_sys = ~clk_sys;
  cafm_top i_dut (.clk_sys(clk_sys), .reset(reset), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
    .rx_ide(rx_ide), .rx_sid(rx_sid), .rx_eid(rx_eid), .filter_hit(filter_hit),
    .hit_filter_index(hit_filter_index), .hit_buffer_pointer(hit_buffer_pointer),
    .hit_to_fifo(hit_to_fifo));
  cafm_can_node i_node (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_ide(rx_ide),
    .rx_sid(rx_sid), .rx_eid(rx_eid));
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask
  // hit is due in the cycle after the frame edge
  task automatic frame(input logic ide, input logic [10:0] standard_identifier_bits, input logic [17:0] extended_identifier_bits,
    input logic hit, input logic [3:0] idx, input logic [3:0] ptr);
    i_node.send(ide, standard_identifier_bits, extended_identifier_bits);
    #1;
    if (hit) begin
      check({filter_hit, hit_to_fifo, hit_filter_index, hit_buffer_pointer},
        {1'b1, ptr == PTR_FIFO, idx, ptr});
    end else begin
      check({31'h0, filter_hit}, 32'h0);
    end
  endtask
  initial begin
    #100000;
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_BUFPNT_BASE + 12'(4 * i), 32'h0);
      xfer(1'b1, ADDR_BUFPNT_BASE + 12'(4 * i), {16'h0, 4'(4 * i + 3), 4'(4 * i + 2),
        4'(4 * i + 1), 4'(4 * i)});
    end
    rd(ADDR_FEN, 32'h0000ffff);
    rd(ADDR_MSKSEL1, 32'h0);
    rd(12'h008, 32'h0000ba98);
    rd(12'h00c, 32'h0000fedc);
    rd(12'h000, 32'h00003210);
    xfer(1'b1, 12'h118, 32'h0000ffff);
    rd(12'h118, 32'h0000ffeb);
    xfer(1'b0, 12'h0f0, 32'h0);
    check({rerr, rdat[30:0]}, 32'h80000000);
    xfer(1'b1, 12'h004, 32'h0000f7a3);
    rd(12'h004, 32'h0000f7a3);
    xfer(1'b1, 12'h020, 32'h0000ffeb);
    xfer(1'b1, 12'h024, 32'h0000ffff);
    xfer(1'b1, 12'h030, 32'h0000ffe0);
    for (int f = 5; f < 8; f += 2) begin
      xfer(1'b1, 12'h100 + 12'(8 * f), 32'h0000246a);
      xfer(1'b1, 12'h104 + 12'(8 * f), 32'h0000abcd);
    end
    xfer(1'b1, 12'h148, 32'h00000aa0);
    frame(1'b1, 11'h123, 18'h2abcd, 1'b1, 4'h5, 4'ha);
    frame(1'b1, 11'h123, 18'h2abcc, 1'b0, 4'h0, 4'h0);
    frame(1'b1, 11'h122, 18'h2abcd, 1'b0, 4'h0, 4'h0);
    frame(1'b1, 11'h123, 18'h3abcd, 1'b0, 4'h0, 4'h0);
    frame(1'b0, 11'h123, 18'h0, 1'b0, 4'h0, 4'h0);
    frame(1'b0, 11'h055, 18'h0, 1'b1, 4'h9, 4'h9);
    xfer(1'b1, ADDR_FEN, 32'h0000ffdf);
    frame(1'b1, 11'h123, 18'h2abcd, 1'b1, 4'h7, 4'hf);
    xfer(1'b1, ADDR_MSKSEL1, 32'h00004000);
    rd(ADDR_MSKSEL1, 32'h00004000);
    frame(1'b1, 11'h3c3, 18'h1, 1'b1, 4'h7, 4'hf);
    xfer(1'b1, ADDR_MSKSEL1, 32'h00008000);
    frame(1'b0, 11'h123, 18'h0, 1'b1, 4'h7, 4'hf);
    frame(1'b0, 11'h124, 18'h0, 1'b0, 4'h0, 4'h0);
    xfer(1'b1, ADDR_MSKSEL1, 32'h0000c000);
    frame(1'b1, 11'h123, 18'h2abcd, 1'b0, 4'h0, 4'h0);
    // a frame seen while the clock enable is low must leave no hit
    @(posedge clk_sys);
    ce <= 1'b0;
    frame(1'b0, 11'h055, 18'h0, 1'b0, 4'h0, 4'h0);
    @(posedge clk_sys);
    ce <= 1'b1;
    frame(1'b0, 11'h055, 18'h0, 1'b1, 4'h9, 4'h9);
    rd(ADDR_HIT_STATUS, 32'h00008099);
    rd(ADDR_HIT_COUNT, 32'h00000006);
    xfer(1'b1, ADDR_HIT_STATUS, 32'h00008000);
    rd(ADDR_HIT_STATUS, 32'h00000099);
    // low byte lane only
    pstrb <= 4'h1;
    xfer(1'b1, 12'h11c, 32'h00001234);
    pstrb <= 4'hf;
    rd(12'h11c, 32'h00000034);
    end_sim();
  end
endmodule
`default_nettype wire
